// File: src/iwe_defs.svh
`ifndef IWE_DEFS_SVH
`define IWE_DEFS_SVH

// Control byte layout
`define IWE_DEV_CODE 4'ha
`define IWE_CODE_MSB 7
`define IWE_CODE_LSB 4
`define IWE_SEL_MSB 3
`define IWE_SEL_LSB 1
`define IWE_RW_BIT 0

// Address layout: high byte carries bits 12..8 in its low five positions
`define IWE_ADDR_W 13
`define IWE_AHI_W 5
`define IWE_PAGE_W 5
`define IWE_PAGE_CNT 6'h20

// Bit counter values within one nine-clock byte
`define IWE_BIT_FIRST 4'h1
`define IWE_BIT_LAST 4'h7
`define IWE_BIT_ACK 4'h8

// Reset values
`define IWE_PTR_RST 13'h0000
`define IWE_CNT_RST 5'h00

// Timing
`define IWE_CLK_PERIOD_NS 100
`define IWE_BYTE_WRITE_NS 50000
`define IWE_BYTE_WRITE_CYC \
  ((`IWE_BYTE_WRITE_NS + `IWE_CLK_PERIOD_NS - 1) / `IWE_CLK_PERIOD_NS)
`define IWE_PUD_NS 75000
`define IWE_PUD_CYC (`IWE_PUD_NS / `IWE_CLK_PERIOD_NS)

`endif

// File: src/iwe_pkg.sv
`include "iwe_defs.svh"

package iwe_pkg;

  // Link-side byte sequencer states
  typedef enum logic [2:0] {
    l_idle,
    l_ctrl,
    l_ahi,
    l_alo,
    l_data
  } iwe_link_st_t;

  // Array programming engine states
  typedef enum logic [0:0] {
    p_idle,
    p_prog
  } iwe_prog_st_t;

  // Advance an address inside its page, never crossing the page boundary
  function automatic logic [`IWE_ADDR_W-1:0] iwe_page_add(
    input logic [`IWE_ADDR_W-1:0] a,
    input logic [`IWE_PAGE_W-1:0] off
  );
    logic [`IWE_PAGE_W-1:0] low;
    low = a[`IWE_PAGE_W-1:0] + off;
    return {a[`IWE_ADDR_W-1:`IWE_PAGE_W], low};
  endfunction

endpackage

// File: src/iwe_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop level synchroniser, one bit per lane
module iwe_sync
#(
  parameter int W = 1
)
(
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: src/iwe_prog.sv
`timescale 1ns/1ps
`default_nettype none
`include "iwe_defs.svh"

// Sequential programmer: one buffered byte per byte-write time
module iwe_prog
  import iwe_pkg::*;
#(
  parameter int BYTE_CYC = `IWE_BYTE_WRITE_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Launch request
  input wire logic go,
  input wire logic [5:0] count,
  input wire logic [`IWE_ADDR_W-1:0] base,
  // Page buffer read
  output logic [`IWE_PAGE_W-1:0] rd_idx,
  input wire logic [7:0] rd_data,
  // Array write port and status
  output logic busy,
  output logic we,
  output logic [`IWE_ADDR_W-1:0] addr,
  output logic [7:0] data
);

  if (BYTE_CYC < 1 || BYTE_CYC > 65536)
  begin : g_chk
    $error("iwe_prog: BYTE_CYC out of range");
  end

  iwe_prog_st_t st_q;
  logic [15:0] tmr_q;
  logic [5:0] cnt_q;
  logic [`IWE_ADDR_W-1:0] base_q;
  logic [5:0] nxt_idx;

  assign nxt_idx = {1'b0, rd_idx} + 6'h01;

  // Byte timer and slot walk; busy spans count times the byte time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= p_idle;
      tmr_q <= 16'h0000;
      cnt_q <= 6'h00;
      base_q <= `IWE_PTR_RST;
      rd_idx <= `IWE_CNT_RST;
      busy <= 1'b0;
    end
    else
    begin
      case (st_q)
        p_idle:
          if (go)
          begin
            st_q <= p_prog;
            tmr_q <= 16'(BYTE_CYC - 1);
            cnt_q <= count;
            base_q <= base;
            rd_idx <= `IWE_CNT_RST;
            busy <= 1'b1;
          end
        p_prog:
          if (tmr_q == 16'h0000)
          begin
            tmr_q <= 16'(BYTE_CYC - 1);
            rd_idx <= nxt_idx[`IWE_PAGE_W-1:0];
            if (nxt_idx == cnt_q)
            begin
              st_q <= p_idle;
              busy <= 1'b0;
            end
          end
          else
          begin
            tmr_q <= tmr_q - 16'h0001;
          end
        default:
          st_q <= p_idle;
      endcase
    end
  end

  // Write strobe at the end of each byte time, slot j to base plus j, wrapping in the page
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      we <= 1'b0;
      addr <= `IWE_PTR_RST;
      data <= 8'h00;
    end
    else
    begin
      we <= (st_q == p_prog) && (tmr_q == 16'h0000);
      if ((st_q == p_prog) && (tmr_q == 16'h0000))
      begin
        addr <= iwe_page_add(base_q, rd_idx);
        data <= rd_data;
      end
    end
  end

endmodule

`default_nettype wire

// File: src/iwe_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iwe_defs.svh"

// Contract
// - Control byte upper nibble must equal the device code, else unselected.
// - Next three control bits must equal the three strap pins exactly.
// - Control byte bit 0: one means read, zero means write.
// - Matching control byte is acknowledged by low SDA on ninth clock.
// - Every accepted address and data byte is acknowledged on ninth clock.
// - Pointer takes the full address after the low address byte.
// - STOP after data starts the write; no STOP, no commit.
// - No control byte acknowledge while a write cycle is running.
// - Byte write advances pointer by one, wrapping inside the page.
// - Protected byte write: acknowledged, no cycle, pointer still advanced.
// - Page write gathers up to 32 bytes, committed after STOP.
// - Over 32 bytes, the page buffer wraps and overwrites earliest.
// - Page data goes to successive addresses wrapping within the page.
// - Protected page write: acknowledged, not done, pointer advanced by count.
// - Page commit programs bytes one after another, busy scales by count.
// - Write protect high blocks all writes; low allows them.
// - Write protect is sampled at STOP; later changes do nothing.
// - Power-on reset lasts at most the stated time before responding.
// - Bytes are eight bits MSB first plus one acknowledge bit.

module iwe_top
  import iwe_pkg::*;
#(
  parameter int BYTE_WRITE_CYC = `IWE_BYTE_WRITE_CYC,
  parameter int PUD_CYC = `IWE_PUD_CYC
)
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Two-wire link, SCL clocks the link logic
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Straps and write protect
  input wire logic select_strap_low,
  input wire logic select_strap_mid,
  input wire logic select_strap_high,
  input wire logic write_protect,
  // Array write port
  output logic mem_we,
  output logic [`IWE_ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_data,
  // Status
  output logic [`IWE_ADDR_W-1:0] address_pointer,
  output logic write_busy,
  output logic power_up_done
);

  if (PUD_CYC < 1 || PUD_CYC > 65536)
  begin : g_chk
    $error("iwe_top: PUD_CYC out of range");
  end

  // Link domain state
  iwe_link_st_t lst_q;
  iwe_link_st_t nxt_st;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic ack_q;
  logic ack_d;
  logic start_tgl_q;
  logic start_seen_q;
  logic stop_tgl_q;
  logic start_evt;
  logic byte_done;
  logic [7:0] byte_w;
  logic ctrl_match;
  logic [2:0] strap_s;
  logic ready_s;
  logic [`IWE_AHI_W-1:0] addr_hi_q;
  logic [7:0] addr_lo_q;
  logic addr_ok_q;
  logic load_tgl_q;
  logic data_any_q;
  logic [`IWE_PAGE_W-1:0] fill_q;
  logic full_q;
  logic [7:0] buf_q [0:31];
  logic sda_out_q;
  logic sda_oe_n_q;

  // Reference domain state
  logic [2:0] pins_s;
  logic stop_prev_q;
  logic load_prev_q;
  logic stop_evt;
  logic load_evt;
  logic [15:0] por_cnt_q;
  logic por_done_q;
  logic ready_q;
  logic launch_d;
  logic [`IWE_ADDR_W-1:0] ptr_q;
  logic [`IWE_ADDR_W-1:0] addr_full;
  logic [5:0] commit_cnt;
  logic [`IWE_PAGE_W-1:0] rd_idx;
  logic prog_busy;

  // Strap pins and the ready level into the link domain
  iwe_sync #(.W(4)) u_link_sync (
    .clk(scl),
    .rst(rst),
    .d({ready_q, select_strap_high, select_strap_mid, select_strap_low}),
    .q({ready_s, strap_s})
  );

  // Frame markers: SDA edges while SCL is high
  always_ff @(negedge sda_in or posedge rst)
  begin
    if (rst)
      start_tgl_q <= 1'b0;
    else if (scl)
      start_tgl_q <= ~start_tgl_q;
  end

  always_ff @(posedge sda_in or posedge rst)
  begin
    if (rst)
      stop_tgl_q <= 1'b0;
    else if (scl)
      stop_tgl_q <= ~stop_tgl_q;
  end

  assign start_evt = start_tgl_q != start_seen_q;
  assign byte_w = {shift_q[6:0], sda_in};
  assign byte_done = !start_evt && (lst_q != l_idle) &&
                     (bit_cnt_q == `IWE_BIT_LAST);
  assign ctrl_match =
    (byte_w[`IWE_CODE_MSB:`IWE_CODE_LSB] == `IWE_DEV_CODE) &&
    (byte_w[`IWE_SEL_MSB:`IWE_SEL_LSB] == strap_s) &&
    ready_s;

  // Acknowledge decision and next state for the byte now complete
  always_comb
  begin
    ack_d = 1'b0;
    nxt_st = l_idle;
    case (lst_q)
      l_ctrl:
        if (ctrl_match)
        begin
          ack_d = 1'b1;
          nxt_st = byte_w[`IWE_RW_BIT] ? l_idle : l_ahi;
        end
      l_ahi:
      begin
        ack_d = 1'b1;
        nxt_st = l_alo;
      end
      l_alo:
      begin
        ack_d = 1'b1;
        nxt_st = l_data;
      end
      l_data:
      begin
        ack_d = 1'b1;
        nxt_st = l_data;
      end
      default:
      begin
        ack_d = 1'b0;
        nxt_st = l_idle;
      end
    endcase
  end

  // Bit counter and shifter, MSB first, nine clocks per byte
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      lst_q <= l_idle;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      start_seen_q <= 1'b0;
    end
    else if (start_evt)
    begin
      start_seen_q <= start_tgl_q;
      lst_q <= l_ctrl;
      bit_cnt_q <= `IWE_BIT_FIRST;
      shift_q <= {7'h00, sda_in};
      ack_q <= 1'b0;
    end
    else if (bit_cnt_q == `IWE_BIT_ACK)
    begin
      bit_cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end
    else if (lst_q != l_idle)
    begin
      shift_q <= byte_w;
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (byte_done)
      begin
        ack_q <= ack_d;
        lst_q <= ack_d ? nxt_st : l_idle;
      end
    end
  end

  // Address capture and page fill count; each START clears the fill count and flags, not the address bytes
  always_ff @(posedge scl or posedge rst)
  begin
    if (rst)
    begin
      addr_hi_q <= 5'h00;
      addr_lo_q <= 8'h00;
      addr_ok_q <= 1'b0;
      load_tgl_q <= 1'b0;
      data_any_q <= 1'b0;
      fill_q <= `IWE_CNT_RST;
      full_q <= 1'b0;
    end
    else if (start_evt)
    begin
      addr_ok_q <= 1'b0;
      data_any_q <= 1'b0;
      fill_q <= `IWE_CNT_RST;
      full_q <= 1'b0;
    end
    else if (byte_done)
    begin
      case (lst_q)
        l_ahi:
          addr_hi_q <= byte_w[`IWE_AHI_W-1:0];
        l_alo:
        begin
          addr_lo_q <= byte_w;
          addr_ok_q <= 1'b1;
          load_tgl_q <= ~load_tgl_q;
        end
        l_data:
        begin
          data_any_q <= 1'b1;
          fill_q <= fill_q + 5'h01;
          if (fill_q == 5'h1f)
            full_q <= 1'b1;
        end
        default:
          data_any_q <= data_any_q;
      endcase
    end
  end

  // Page buffer, written at the slot that wraps every 32 bytes
  always_ff @(posedge scl)
  begin
    if (byte_done && lst_q == l_data)
      buf_q[fill_q] <= byte_w;
  end

  // Open-drain drive: low through the ninth clock of an accepted byte
  always_ff @(negedge scl or posedge rst)
  begin
    if (rst)
    begin
      sda_out_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      sda_out_q <= 1'b0;
      sda_oe_n_q <= !((bit_cnt_q == `IWE_BIT_ACK) && ack_q);
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;

  // STOP, address load and protect level into the reference domain
  iwe_sync #(.W(3)) u_ref_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({load_tgl_q, stop_tgl_q, write_protect}),
    .q(pins_s)
  );

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stop_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end
    else
    begin
      stop_prev_q <= pins_s[1];
      load_prev_q <= pins_s[2];
    end
  end

  assign stop_evt = pins_s[1] != stop_prev_q;
  assign load_evt = pins_s[2] != load_prev_q;

  // Power-on hold, released after the power-up delay count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      por_cnt_q <= 16'h0000;
      por_done_q <= 1'b0;
    end
    else if (!por_done_q)
    begin
      por_cnt_q <= por_cnt_q + 16'h0001;
      if (por_cnt_q == 16'(PUD_CYC - 1))
        por_done_q <= 1'b1;
    end
  end

  // Link values are frozen after STOP, since SCL then stands still
  assign addr_full = {addr_hi_q, addr_lo_q};
  assign commit_cnt = full_q ? `IWE_PAGE_CNT : {1'b0, fill_q};
  assign launch_d = stop_evt && data_any_q && !pins_s[0] &&
                    por_done_q && !prog_busy;

  // Address pointer: loaded mid-frame, advanced in-page at STOP
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ptr_q <= `IWE_PTR_RST;
    else if (stop_evt && addr_ok_q)
      ptr_q <= iwe_page_add(addr_full, fill_q);
    else if (load_evt)
      ptr_q <= addr_full;
  end

  // Ready level drops in the launch cycle and stays low while busy
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ready_q <= 1'b0;
    else
      ready_q <= por_done_q && !prog_busy && !launch_d;
  end

  iwe_prog #(.BYTE_CYC(BYTE_WRITE_CYC)) u_prog (
    .clk(ref_clk),
    .rst(rst),
    .go(launch_d),
    .count(commit_cnt),
    .base(addr_full),
    .rd_idx(rd_idx),
    .rd_data(buf_q[rd_idx]),
    .busy(prog_busy),
    .we(mem_we),
    .addr(mem_addr),
    .data(mem_data)
  );

  assign address_pointer = ptr_q;
  assign write_busy = prog_busy;
  assign power_up_done = por_done_q;

endmodule
`default_nettype wire

// File: verif/iwe_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the write engine
module iwe_top_sva
#(
  parameter int BYTE_WRITE_CYC = 500,
  parameter int PUD_CYC = 750
)
(
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  // Link outputs
  input wire logic sda_oe_n,
  // Array port and status
  input wire logic mem_we,
  input wire logic [12:0] mem_addr,
  input wire logic [12:0] address_pointer,
  input wire logic write_busy,
  input wire logic power_up_done
);
  // Wide enough for the full-length byte time and power-up delay
  logic [15:0] gap_q;
  logic [15:0] pud_q;
  logic seq_q;
  logic [12:0] last_q;

  // Cycles since busy began or since the previous array write
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) gap_q <= 16'h0000;
    else if (mem_we) gap_q <= 16'h0001;
    else if (write_busy) gap_q <= gap_q + 16'h0001;
    else gap_q <= 16'h0000;

  // Cycles spent waiting for power-up
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) pud_q <= 16'h0000;
    else if (!power_up_done && pud_q != 16'hffff) pud_q <= pud_q + 16'h0001;

  // Marks a second or later write of one commit
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) seq_q <= 1'b0;
    else seq_q <= write_busy && (mem_we || seq_q);

  // Address of the previous array write
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) last_q <= 13'h0000;
    else if (mem_we) last_q <= mem_addr;

  a_ack_one_clock: assert property (@(posedge scl) disable iff (rst)
    !sda_oe_n |=> sda_oe_n) else $error("ack held too long");
  a_no_ack_busy: assert property (@(posedge ref_clk) disable iff (rst)
    write_busy |-> sda_oe_n) else $error("ack during write cycle");
  a_we_in_busy: assert property (@(posedge ref_clk) disable iff (rst)
    mem_we |-> $past(write_busy)) else $error("write outside cycle");
  a_we_spacing: assert property (@(posedge ref_clk) disable iff (rst)
    mem_we |-> gap_q >= BYTE_WRITE_CYC - 1 && gap_q <= BYTE_WRITE_CYC + 1)
    else $error("write spacing wrong");
  a_busy_ends_we: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(write_busy) |-> mem_we) else $error("busy ended without write");
  a_page_step: assert property (@(posedge ref_clk) disable iff (rst)
    mem_we && seq_q |-> mem_addr == {last_q[12:5], last_q[4:0] + 5'h01})
    else $error("page address step wrong");
  a_ptr_hold_busy: assert property (@(posedge ref_clk) disable iff (rst)
    write_busy && $past(write_busy, 2) |-> $stable(address_pointer))
    else $error("pointer moved in cycle");
  a_pwr_bound: assert property (@(posedge ref_clk) disable iff (rst)
    pud_q <= PUD_CYC + 2) else $error("power-up too slow");
  a_ack_needs_pwr: assert property (@(posedge ref_clk) disable iff (rst)
    !sda_oe_n |-> power_up_done) else $error("ack before power-up");

  // Main scenarios reached
  c_page: cover property (@(posedge ref_clk) mem_we && seq_q);
  c_busy_end: cover property (@(posedge ref_clk) $fell(write_busy));
  c_ack: cover property (@(posedge scl) !sda_oe_n);
endmodule

bind iwe_top iwe_top_sva #(
  .BYTE_WRITE_CYC(BYTE_WRITE_CYC),
  .PUD_CYC(PUD_CYC)
) chk_u (
  .ref_clk(ref_clk),
  .rst(rst),
  .scl(scl),
  .sda_oe_n(sda_oe_n),
  .mem_we(mem_we),
  .mem_addr(mem_addr),
  .address_pointer(address_pointer),
  .write_busy(write_busy),
  .power_up_done(power_up_done)
);

`default_nettype wire

// File: verif/iwe_master.sv
`timescale 1ns/1ps
`default_nettype none

// Two-wire bus master, 80 ns clock, clock held still between frames
module iwe_master
(
  // Resolved data line, our clock and our data drive
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // Idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // START, also used as repeated START to restart a frame
  task automatic start();
    #7 sda_drv = 1'b1;
    #20 scl = 1'b1;
    #20 sda_drv = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask

  // One clock: data set mid-low, sampled mid-high
  task automatic bit_clk(input logic v, output logic s);
    sda_drv = v;
    #20 scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
    #20;
  endtask

  // Eight bits MSB first, then a released acknowledge clock
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_clk(b[i], ack);
    bit_clk(1'b1, ack);
    ack = !ack;
  endtask

  // STOP, then the clock stays high
  task automatic stop();
    sda_drv = 1'b0;
    #20 scl = 1'b1;
    #20 sda_drv = 1'b1;
    #20;
  endtask
endmodule

`default_nettype wire

// File: verif/iwe_top_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("FAIL %0t value mismatch, got %0h", $time, (got)); \
    end \
  end

module iwe_top_test;
  import iwe_pkg::*;
  localparam int BWC = 40;
  localparam int PUD = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic [2:0] strap = 3'h0;
  logic wp = 1'b0;
  logic scl, sda_drv, sda_w, sda_out, sda_oe_n;
  logic mem_we, write_busy, power_up_done;
  logic [12:0] mem_addr, address_pointer;
  logic [7:0] mem_data;
  logic [20:0] exp_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int busy_cyc = 0;

  always #50 ref_clk = ~ref_clk;
  // Open-drain wire with pull-up
  assign sda_w = sda_drv & (sda_oe_n | sda_out);

  iwe_top #(.BYTE_WRITE_CYC(BWC), .PUD_CYC(PUD)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .select_strap_low(strap[0]), .select_strap_mid(strap[1]),
    .select_strap_high(strap[2]), .write_protect(wp),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data),
    .address_pointer(address_pointer), .write_busy(write_busy),
    .power_up_done(power_up_done));

  iwe_master m_u (.sda(sda_w), .scl(scl), .sda_drv(sda_drv));

  // Every array write must match the next expected one
  always @(posedge ref_clk)
  begin
    if (write_busy === 1'b1)
      busy_cyc++;
    if (mem_we === 1'b1)
      `CHK(({mem_addr, mem_data}), (exp_q.size() > 0 ? exp_q.pop_front() : 21'h0))
  end

  // In-page address advance
  function automatic logic [12:0] pg_add(input logic [12:0] a, input int off);
    return {a[12:5], 5'(a[4:0] + off)};
  endfunction

  // Write frame with n random data bytes, STOP optional
  task automatic wr(input logic [12:0] a, input int n, input bit stp);
    logic [7:0] d;
    logic [7:0] pb [32];
    logic ack;
    m_u.start();
    m_u.xfer({4'ha, strap, 1'b0}, ack);
    `CHK(ack, 1'b1)
    m_u.xfer({3'h0, a[12:8]}, ack);
    `CHK(ack, 1'b1)
    m_u.xfer(a[7:0], ack);
    `CHK(ack, 1'b1)
    repeat (5) @(posedge ref_clk);
    `CHK(address_pointer, a)
    for (int k = 0; k < n; k++)
    begin
      d = 8'($urandom);
      pb[k % 32] = d;
      m_u.xfer(d, ack);
      `CHK(ack, 1'b1)
    end
    if (stp && !wp)
      for (int s = 0; s < ((n < 32) ? n : 32); s++)
        exp_q.push_back({pg_add(a, s), pb[s]});
    if (stp)
    begin
      m_u.stop();
      repeat (5) @(posedge ref_clk);
      `CHK(address_pointer, pg_add(a, n))
    end
  endtask

  // Poll with the control byte that began the write
  task automatic poll(input bit busy_exp);
    logic ack;
    m_u.start();
    m_u.xfer({4'ha, strap, 1'b0}, ack);
    m_u.stop();
    repeat (5) @(posedge ref_clk);
    `CHK(ack, !busy_exp)
  endtask

  // Wait out the write cycle, then expect an acknowledge
  task automatic drain();
    int t;
    t = 0;
    while (write_busy !== 1'b0 && t < 2000)
    begin
      @(posedge ref_clk);
      t++;
    end
    `CHK(t < 2000, 1'b1)
    repeat (2) @(posedge ref_clk);
    poll(1'b0);
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [7:0] ctl;
    logic ack;
    // A real rising edge, so the link-side flops reset with SCL still
    rst <= 1'b1;
    void'($urandom(66));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    strap <= 3'($urandom);
    @(posedge ref_clk);
    `CHK(power_up_done, 1'b0)
    repeat (PUD) @(posedge ref_clk);
    `CHK(power_up_done, 1'b1)
    repeat (8) @(posedge ref_clk);
    // Single strap bit wrong, code wrong, then a matching read
    for (int i = 0; i < 5; i++)
    begin
      ctl = {4'ha, strap, 1'b0};
      if (i < 3) ctl[3:1] = ctl[3:1] ^ 3'(1 << i);
      if (i == 3) ctl[7:4] = 4'h8;
      if (i == 4) ctl[0] = 1'b1;
      m_u.start();
      m_u.xfer(ctl, ack);
      m_u.stop();
      repeat (5) @(posedge ref_clk);
      `CHK(ack, i == 4)
    end
    // Byte write at page end, protect raised during the cycle
    busy_cyc = 0;
    wr(13'h001f, 1, 1'b1);
    wp <= 1'b1;
    poll(1'b1);
    drain();
    `CHK(busy_cyc, BWC)
    wp <= 1'b0;
    // Ten-byte page that wraps inside its page
    busy_cyc = 0;
    wr(13'h087a, 10, 1'b1);
    poll(1'b1);
    drain();
    `CHK(busy_cyc, 10 * BWC)
    // Overfilled page buffer
    wr(13'($urandom), 35, 1'b1);
    drain();
    // Protected page: no cycle, ready at once
    wp <= 1'b1;
    wr(13'($urandom), 1 + $urandom % 8, 1'b1);
    `CHK(write_busy, 1'b0)
    poll(1'b0);
    wp <= 1'b0;
    // Data without STOP, then a refused restart
    wr(13'($urandom), 3, 1'b0);
    m_u.start();
    m_u.xfer({4'h8, strap, 1'b0}, ack);
    `CHK(ack, 1'b0)
    m_u.stop();
    repeat (60) @(posedge ref_clk);
    // Random writes, protect random
    repeat (4)
    begin
      wp <= 1'($urandom);
      @(posedge ref_clk);
      wr(13'($urandom), 1 + $urandom % 6, 1'b1);
      drain();
    end
    `CHK(exp_q.size(), 0)
    print_verdict();
  end

  // Watchdog: the tests need well under 8000 cycles
  initial
  begin
    #(20000 * 100);
    n_mismatch++;
    print_verdict();
  end
endmodule

`default_nettype wire
